// [cdt_top.sv]
`timescale 1ns/1ps
module cdt_top (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [5:0] s_axi_awaddr_i,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  // AXI4-Lite write response
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [5:0] s_axi_araddr_i,
  // AXI4-Lite read data
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // Core state
  input wire logic cpu_idle_i,
  // Pins
  input wire logic ext_clk_lo_i,
  input wire logic gate_lo_i,
  input wire logic ext_clk_hi_i,
  input wire logic gate_hi_i,
  // Events
  output logic irq_o,
  output logic adc_trig_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] lo_ctl_q, hi_ctl_q;
  logic [15:0] lo_cnt_q, lo_cnt_d, hi_cnt_q, hi_cnt_d;
  localparam int IRQ_W_L = cdt_pkg::IRQ_W;
  logic [15:0] hold_q, hold_d;
  logic [15:0] lo_per_q, hi_per_q;
  logic [IRQ_W_L-1:0] sts_q, sts_d, msk_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_full_q, w_full_q;
  logic [5:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic irq_q, trig_q;

  // ----------------------------------------------------------------
  // Effective controls
  // ----------------------------------------------------------------
  wire mode32 = lo_ctl_q[cdt_pkg::CTL_MODE32];
  // Chained: high half takes low half's setup
  wire [15:0] hi_eff = mode32 ? lo_ctl_q : hi_ctl_q;
  wire lo_run = lo_ctl_q[cdt_pkg::CTL_ON] &
    ~(cpu_idle_i & lo_ctl_q[cdt_pkg::CTL_IDLE_STOP]);
  wire hi_run = ~mode32 & hi_eff[cdt_pkg::CTL_ON] &
    ~(cpu_idle_i & hi_eff[cdt_pkg::CTL_IDLE_STOP]);
  wire tick_lo, tick_hi;

  // ----------------------------------------------------------------
  // Prescalers
  // ----------------------------------------------------------------
  cdt_prescale #(.SYNC_OUT(1'b1)) u_ps_lo (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .run_i(lo_run),
    .ext_sel_i(lo_ctl_q[cdt_pkg::CTL_EXT]),
    .gate_en_i(lo_ctl_q[cdt_pkg::CTL_GATE]),
    .ps_sel_i(lo_ctl_q[cdt_pkg::CTL_PS_LSB +: 2]),
    .ext_clk_i(ext_clk_lo_i),
    .gate_i(gate_lo_i),
    .tick_o(tick_lo)
  );

  cdt_prescale #(.SYNC_OUT(1'b0)) u_ps_hi (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .run_i(hi_run),
    .ext_sel_i(hi_ctl_q[cdt_pkg::CTL_EXT]),
    .gate_en_i(hi_ctl_q[cdt_pkg::CTL_GATE]),
    .ps_sel_i(hi_ctl_q[cdt_pkg::CTL_PS_LSB +: 2]),
    .ext_clk_i(ext_clk_hi_i),
    .gate_i(gate_hi_i),
    .tick_o(tick_hi)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire wr_fire = aw_full_q & w_full_q & ~bvalid_q;
  wire rd_fire = s_axi_arvalid_i & arready_q;
  wire [15:0] wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire wr_lo_ctl = wr_fire & (awaddr_q == cdt_pkg::OFS_LO_CTL);
  wire wr_hi_ctl = wr_fire & (awaddr_q == cdt_pkg::OFS_HI_CTL);
  wire wr_lo_cnt = wr_fire & (awaddr_q == cdt_pkg::OFS_LO_CNT);
  wire wr_hi_cnt = wr_fire & (awaddr_q == cdt_pkg::OFS_HI_CNT);
  wire wr_hold = wr_fire & (awaddr_q == cdt_pkg::OFS_HOLD);
  wire wr_lo_per = wr_fire & (awaddr_q == cdt_pkg::OFS_LO_PER);
  wire wr_hi_per = wr_fire & (awaddr_q == cdt_pkg::OFS_HI_PER);
  wire wr_sts = wr_fire & (awaddr_q == cdt_pkg::OFS_IRQ_STS);
  wire wr_msk = wr_fire & (awaddr_q == cdt_pkg::OFS_IRQ_MSK);
  wire wr_hit = wr_lo_ctl | wr_hi_ctl | wr_lo_cnt | wr_hi_cnt | wr_hold |
    wr_lo_per | wr_hi_per | wr_sts | wr_msk;
  wire rd_lo_cnt = rd_fire & (s_axi_araddr_i == cdt_pkg::OFS_LO_CNT);

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] nw,
                                        input logic [15:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  wire [15:0] wd16 = wdata_q[15:0];

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  wire [31:0] cnt32 = {hi_cnt_q, lo_cnt_q};
  wire [31:0] per32 = {hi_per_q, lo_per_q};
  wire [31:0] inc32 = cnt32 + 32'h0000_0001;
  wire step32 = mode32 & tick_lo;
  wire match32 = step32 & (cnt32 == per32);
  wire step_lo = ~mode32 & tick_lo;
  wire step_hi = ~mode32 & tick_hi;
  wire match_lo = step_lo & (lo_cnt_q == lo_per_q);
  wire match_hi = step_hi & (hi_cnt_q == hi_per_q);
  wire [15:0] lo_nxt = match_lo ? 16'h0000 : lo_cnt_q + 16'h0001;
  wire [15:0] hi_nxt = match_hi ? 16'h0000 : hi_cnt_q + 16'h0001;

  always_comb begin
    lo_cnt_d = lo_cnt_q;
    hi_cnt_d = hi_cnt_q;
    if (step32) begin
      lo_cnt_d = match32 ? 16'h0000 : inc32[15:0];
      hi_cnt_d = match32 ? 16'h0000 : inc32[31:16];
    end else begin
      if (step_lo) begin
        lo_cnt_d = lo_nxt;
      end
      if (step_hi) begin
        hi_cnt_d = hi_nxt;
      end
    end
    // Software load beats counting
    if (wr_lo_cnt) begin
      lo_cnt_d = merge(lo_cnt_q, wd16, wmask);
      if (mode32) begin
        hi_cnt_d = hold_q;
      end
    end
    if (wr_hi_cnt) begin
      hi_cnt_d = merge(hi_cnt_q, wd16, wmask);
    end
  end

  // Write to latch beats read capture
  assign hold_d = wr_hold ? merge(hold_q, wd16, wmask) :
                  rd_lo_cnt ? hi_cnt_q : hold_q;

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  wire [IRQ_W_L-1:0] sts_set = {match32 | match_hi, match_lo};
  wire [IRQ_W_L-1:0] sts_clr = wr_sts ? wdata_q[IRQ_W_L-1:0] : '0;
  assign sts_d = (sts_q & ~sts_clr) | sts_set;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr_i)
      cdt_pkg::OFS_LO_CTL: rd_mux = {16'h0000, lo_ctl_q};
      cdt_pkg::OFS_HI_CTL: rd_mux = {16'h0000, hi_ctl_q};
      cdt_pkg::OFS_LO_CNT: rd_mux = {16'h0000, lo_cnt_q};
      cdt_pkg::OFS_HI_CNT: rd_mux = {16'h0000, hi_cnt_q};
      cdt_pkg::OFS_HOLD: rd_mux = {16'h0000, hold_q};
      cdt_pkg::OFS_LO_PER: rd_mux = {16'h0000, lo_per_q};
      cdt_pkg::OFS_HI_PER: rd_mux = {16'h0000, hi_per_q};
      cdt_pkg::OFS_IRQ_STS: rd_mux = {30'h0000_0000, sts_q};
      cdt_pkg::OFS_IRQ_MSK: rd_mux = {30'h0000_0000, msk_q};
      default: rd_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      lo_ctl_q <= cdt_pkg::CTL_RST;
      hi_ctl_q <= cdt_pkg::CTL_RST;
      lo_cnt_q <= cdt_pkg::CNT_RST;
      hi_cnt_q <= cdt_pkg::CNT_RST;
      hold_q <= cdt_pkg::CNT_RST;
      lo_per_q <= cdt_pkg::PER_RST;
      hi_per_q <= cdt_pkg::PER_RST;
      sts_q <= cdt_pkg::IRQ_RST;
      msk_q <= cdt_pkg::IRQ_RST;
      irq_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      if (wr_lo_ctl) begin
        lo_ctl_q <= merge(lo_ctl_q, wd16, wmask) & cdt_pkg::LO_CTL_MASK;
      end
      if (wr_hi_ctl) begin
        hi_ctl_q <= merge(hi_ctl_q, wd16, wmask) & cdt_pkg::HI_CTL_MASK;
      end
      if (wr_lo_per) begin
        lo_per_q <= merge(lo_per_q, wd16, wmask);
      end
      if (wr_hi_per) begin
        hi_per_q <= merge(hi_per_q, wd16, wmask);
      end
      if (wr_msk) begin
        msk_q <= wdata_q[IRQ_W_L-1:0];
      end
      lo_cnt_q <= lo_cnt_d;
      hi_cnt_q <= hi_cnt_d;
      hold_q <= hold_d;
      sts_q <= sts_d;
      irq_q <= |(sts_d & msk_q);
      trig_q <= mode32 ? match32 : match_hi;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 6'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= cdt_pkg::RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= cdt_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && awready_q) begin
        awaddr_q <= {s_axi_awaddr_i[5:2], 2'h0};
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid_i && wready_q) begin
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? cdt_pkg::RESP_OKAY : cdt_pkg::RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready_i) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
      if (rd_fire) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_ok ? cdt_pkg::RESP_OKAY : cdt_pkg::RESP_SLVERR;
      end
      if (rvalid_q && s_axi_rready_i) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign irq_o = irq_q;
  assign adc_trig_o = trig_q;
endmodule // cdt_top

// [cdt_pkg.sv]
package cdt_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_LO_CTL = 6'h00;
  localparam logic [5:0] OFS_HI_CTL = 6'h04;
  localparam logic [5:0] OFS_LO_CNT = 6'h08;
  localparam logic [5:0] OFS_HI_CNT = 6'h0C;
  localparam logic [5:0] OFS_HOLD = 6'h10;
  localparam logic [5:0] OFS_LO_PER = 6'h14;
  localparam logic [5:0] OFS_HI_PER = 6'h18;
  localparam logic [5:0] OFS_IRQ_STS = 6'h1C;
  localparam logic [5:0] OFS_IRQ_MSK = 6'h20;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTL_ON = 15;
  localparam int CTL_IDLE_STOP = 13;
  localparam int CTL_GATE = 6;
  localparam int CTL_PS_LSB = 4;
  localparam int CTL_MODE32 = 3;
  localparam int CTL_EXT = 1;
  localparam logic [15:0] LO_CTL_MASK = 16'hA07A;
  localparam logic [15:0] HI_CTL_MASK = 16'hA072;

  // ----------------------------------------------------------------
  // Status and mask bit positions
  // ----------------------------------------------------------------
  localparam int IRQ_LO = 0;
  localparam int IRQ_HI = 1;
  localparam int IRQ_W = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] PER_RST = 16'hFFFF;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  // ----------------------------------------------------------------
  // Prescaler terminal counts for 1, 8, 64, 256
  // ----------------------------------------------------------------
  localparam logic [7:0] PS_TC0 = 8'h00;
  localparam logic [7:0] PS_TC1 = 8'h07;
  localparam logic [7:0] PS_TC2 = 8'h3F;
  localparam logic [7:0] PS_TC3 = 8'hFF;

  // ----------------------------------------------------------------
  // AXI responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [cdt_prescale.sv]
`timescale 1ns/1ps
module cdt_prescale #(
  parameter bit SYNC_OUT = 1'b0
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Controls
  input wire logic run_i,
  input wire logic ext_sel_i,
  input wire logic gate_en_i,
  input wire logic [1:0] ps_sel_i,
  // Pins
  input wire logic ext_clk_i,
  input wire logic gate_i,
  // Count enable
  output logic tick_o
);
  logic [2:0] clk_sync_q;
  logic [1:0] gate_sync_q;
  logic [7:0] ps_q;
  logic [7:0] ps_d;
  logic tick_q;
  wire ext_rise = clk_sync_q[1] & ~clk_sync_q[2];
  wire src_evt = ext_sel_i ? ext_rise : 1'b1;
  wire gate_ok = ~gate_en_i | gate_sync_q[1];
  wire evt = run_i & src_evt & gate_ok;
  wire [7:0] tc = (ps_sel_i == 2'h0) ? cdt_pkg::PS_TC0 :
                  (ps_sel_i == 2'h1) ? cdt_pkg::PS_TC1 :
                  (ps_sel_i == 2'h2) ? cdt_pkg::PS_TC2 : cdt_pkg::PS_TC3;
  wire ps_wrap = evt & (ps_q >= tc);

  assign ps_d = ps_wrap ? 8'h00 : (evt ? ps_q + 8'h01 : ps_q);

  // Edges synchronised to the core clock
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      clk_sync_q <= 3'h0;
      gate_sync_q <= 2'h0;
      ps_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      clk_sync_q <= {clk_sync_q[1:0], ext_clk_i};
      gate_sync_q <= {gate_sync_q[0], gate_i};
      ps_q <= run_i ? ps_d : 8'h00;
      tick_q <= ps_wrap & run_i;
    end
  end

  // Low half retimes the divider output, high half passes it through
  assign tick_o = SYNC_OUT ? (tick_q & run_i) : ps_wrap;
endmodule // cdt_prescale

// [cdt_ext_src.sv]
`timescale 1ns/1ps
module cdt_ext_src #(
  parameter int HALF = 3
) (
  // Clock
  input wire logic core_clk_i,
  // Burst request
  input wire logic go_i,
  input wire logic [7:0] n_i,
  // Pin and state
  output logic ext_clk_o,
  output logic busy_o
);
  int cnt = 0;
  int ph = 0;
  initial ext_clk_o = 1'b0;
  initial busy_o = 1'b0;
  // --------------------------------------------------------------
  // Burst of n rising edges, pin held low between bursts
  // --------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (!busy_o && go_i && n_i != 8'h00) begin
      busy_o <= 1'b1;
      cnt <= 2 * n_i;
      ph <= HALF;
    end else if (busy_o) begin
      if (ph > 1) begin
        ph <= ph - 1;
      end else if (cnt == 0) begin
        busy_o <= 1'b0;
      end else begin
        ext_clk_o <= ~ext_clk_o;
        cnt <= cnt - 1;
        ph <= HALF;
      end
    end
  end
endmodule // cdt_ext_src

// [cdt_top_sva.sv]
`timescale 1ns/1ps
module cdt_top_sva (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Bus
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [5:0] s_axi_araddr_i,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  AST_RD_LAT: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o && !s_axi_arready_o) else $error("read late");
  AST_RD_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)
    && $stable(s_axi_rresp_o)) else $error("read answer moved");
  AST_RD_DONE: assert property (s_axi_rvalid_o && s_axi_rready_i
    |=> !s_axi_rvalid_o && s_axi_arready_o) else $error("read end");
  AST_WR_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("b moved");
  AST_WR_LAT: assert property (s_axi_awvalid_i && s_axi_awready_o
    && s_axi_wvalid_i && s_axi_wready_o |=> !s_axi_awready_o
    && !s_axi_wready_o ##1 s_axi_bvalid_o) else $error("write late");
  AST_WR_BUSY: assert property (s_axi_bvalid_o
    |-> !s_axi_awready_o && !s_axi_wready_o) else $error("write busy");
  AST_WR_DONE: assert property (s_axi_bvalid_o && s_axi_bready_i
    |=> !s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o)
    else $error("write end");
  AST_RD_UNMAP: assert property (s_axi_arvalid_i && s_axi_arready_o
    && s_axi_araddr_i >= 6'h24 |=> s_axi_rresp_o == 2'h2
    && s_axi_rdata_o == 32'h0) else $error("unmapped read");
  AST_RD_UPPER: assert property (s_axi_rvalid_o
    |-> s_axi_rdata_o[31:16] == 16'h0) else $error("upper bits set");
endmodule // cdt_top_sva
bind cdt_top cdt_top_sva i_sva (
  .core_clk_i(core_clk_i),
  .nrst_i(nrst_i),
  .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i),
  .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o),
  .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i),
  .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o)
);

// [cdt_top_test.sv]
`timescale 1ns/1ps
module cdt_top_test;
  logic clk = 1'b0, nrst = 1'b0, idle = 1'b0, ghi = 1'b0, glo = 1'b0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic golo = 1'b0, gohi = 1'b0;
  logic [7:0] n = 8'h0;
  logic [5:0] awa = 6'h0, ara = 6'h0;
  logic [31:0] wd = 32'h0;
  logic awr, wrd, bv, arr, rv, irq, trig, elo, ehi, blo, bhi;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  int n_errors = 0;
  int comparisons = 0;
  always #2 clk = ~clk;
  cdt_top i_dut (.core_clk_i(clk), .nrst_i(nrst),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(br), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .cpu_idle_i(idle), .ext_clk_lo_i(elo), .gate_lo_i(glo),
    .ext_clk_hi_i(ehi), .gate_hi_i(ghi), .irq_o(irq),
    .adc_trig_o(trig));
  cdt_ext_src i_slo (.core_clk_i(clk), .go_i(golo), .n_i(n),
    .ext_clk_o(elo), .busy_o(blo));
  cdt_ext_src i_shi (.core_clk_i(clk), .go_i(gohi), .n_i(n),
    .ext_clk_o(ehi), .busy_o(bhi));
  // --------------------------------------------------------------
  // Bus and compare helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    br <= 1'b1;
    forever begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) break;
    end
    resp = bresp;
  endtask
  task automatic rdr(input logic [5:0] a);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    forever begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rd = rdata;
    resp = rresp;
  endtask
  task automatic wtrig(input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (trig !== 1'b1 && c < lim);
  endtask
  task automatic pulses(input bit hi, input logic [7:0] k);
    n <= k;
    gohi <= hi;
    golo <= !hi;
    @(posedge clk);
    gohi <= 1'b0;
    golo <= 1'b0;
    repeat (2) @(posedge clk);
    while (blo || bhi) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 9; i++) begin
      rdr(6'(4 * i));
      chk(rd, (i == 5 || i == 6) ? 32'hFFFF : 32'h0);
    end
    // Answers must stand while the master stalls
    rr <= 1'b0;
    arv <= 1'b1;
    ara <= 6'h14;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    repeat (3) @(posedge clk);
    rr <= 1'b1;
    do @(posedge clk); while (rv !== 1'b1);
    chk(rdata, 32'hFFFF);
    br <= 1'b0;
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= 6'h20;
    wd <= 32'h0;
    forever begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) break;
    end
    repeat (3) @(posedge clk);
    br <= 1'b1;
    do @(posedge clk); while (bv !== 1'b1);
    chk(32'(bresp), 32'(cdt_pkg::RESP_OKAY));
    rdr(6'h24);
    chk({rd[29:0], resp}, 32'h2);
    wr(6'h24, 32'h1);
    chk(32'(resp), 32'h2);
    wr(6'h00, 32'hFFFF);
    rdr(6'h00);
    chk(rd, 32'(cdt_pkg::LO_CTL_MASK));
    wr(6'h00, 32'h0);
    wr(6'h04, 32'hFFFF);
    rdr(6'h04);
    chk(rd, 32'(cdt_pkg::HI_CTL_MASK));
    wr(6'h04, 32'h0);
  endtask
  task automatic t_tmr16;
    int c;
    wr(6'h0C, 32'h0);
    wr(6'h18, 32'h4);
    wr(6'h20, 32'h2);
    wr(6'h04, 32'h8000);
    wtrig(40, c);
    wtrig(40, c);
    chk(32'(c), 32'h5);
    @(posedge clk);
    chk(irq, 1'b1);
    wr(6'h04, 32'h0);
    wr(6'h1C, 32'h2);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wr(6'h20, 32'h0);
    wr(6'h14, 32'h3);
    wr(6'h00, 32'h8000);
    wr(6'h04, 32'h8000);
    repeat (20) @(posedge clk);
    chk(irq, 1'b0);
    rdr(6'h1C);
    chk(rd, 32'h3);
    wr(6'h00, 32'h0);
    wr(6'h04, 32'h0);
    wr(6'h1C, 32'h3);
  endtask
  task automatic t_ps;
    int dv[4] = '{1, 8, 64, 256};
    int c;
    wr(6'h18, 32'h1);
    wr(6'h0C, 32'h0);
    for (int p = 0; p < 4; p++) begin
      wr(6'h04, 32'h8000 | 32'(p << 4));
      wtrig(600, c);
      wtrig(600, c);
      chk(32'(c), 32'(2 * dv[p]));
      wr(6'h04, 32'h0);
    end
  endtask
  task automatic t_c32;
    int c;
    wr(6'h1C, 32'h3);
    wr(6'h04, 32'h0030);
    wr(6'h18, 32'h2);
    wr(6'h14, 32'h0);
    wr(6'h00, 32'h0008);
    wr(6'h10, 32'h1);
    wr(6'h08, 32'hFFF0);
    rdr(6'h0C);
    chk(rd, 32'h1);
    wr(6'h10, 32'h55);
    rdr(6'h08);
    chk(rd, 32'hFFF0);
    rdr(6'h10);
    chk(rd, 32'h1);
    wr(6'h00, 32'h8008);
    wtrig(40, c);
    chk(32'(c < 40), 32'h1);
    rdr(6'h08);
    chk(32'(rd < 32'h40), 32'h1);
    rdr(6'h10);
    chk(rd, 32'h0);
    rdr(6'h1C);
    chk(rd, 32'h2);
    wr(6'h00, 32'h0);
    wr(6'h1C, 32'h3);
  endtask
  task automatic t_ext;
    wr(6'h14, 32'hFFFF);
    wr(6'h18, 32'hFFFF);
    wr(6'h00, 32'h000A);
    wr(6'h10, 32'h0);
    wr(6'h08, 32'h0);
    wr(6'h00, 32'h800A);
    pulses(0, 8'h6);
    rdr(6'h08);
    chk(rd, 32'h6);
    idle <= 1'b1;
    wr(6'h00, 32'hA00A);
    pulses(0, 8'h4);
    rdr(6'h08);
    chk(rd, 32'h6);
    idle <= 1'b0;
    pulses(0, 8'h3);
    rdr(6'h08);
    chk(rd, 32'h9);
    wr(6'h00, 32'h800A);
    idle <= 1'b1;
    pulses(0, 8'h2);
    rdr(6'h08);
    chk(rd, 32'hB);
    idle <= 1'b0;
    wr(6'h00, 32'h0);
    wr(6'h0C, 32'h0);
    wr(6'h04, 32'h8042);
    pulses(1, 8'h3);
    rdr(6'h0C);
    chk(rd, 32'h0);
    ghi <= 1'b1;
    glo <= 1'b1;
    pulses(1, 8'h3);
    rdr(6'h0C);
    chk(rd, 32'h3);
  endtask
  task automatic complete_run;
    if (n_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs;
    t_tmr16;
    t_ps;
    t_c32;
    t_ext;
    complete_run;
  end
  initial begin
    #200000;
    n_errors++;
    complete_run;
  end
endmodule // cdt_top_test
